// ### testbench/host_bus_model.sv
// Behavioural host that sends programming groups over the strobe and data pins
`default_nettype none

module host_bus_model (
  // Host pins
  output logic o_strobe,
  output logic [5:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // Edge spacing is wider than the link clock asks, so each group stays put for 1.2 us
  localparam int GAP_NS = 1200;

  initial begin
    o_strobe = 1'b0;
    o_data = 6'h15;
  end

  // ==========================================================
  // Send groups first to last, data changes together with the strobe edge
  task automatic send(input logic [47:0] seq, input int n_grp);
    #37;
    for (int g = 0; g < n_grp; g++) begin
      o_data = seq[47 - 6 * g -: 6];
      o_strobe = ~o_strobe;
      #(GAP_NS);
    end
    // Released bus has no pull, so show the inverse rather than a stale value
    o_data = ~o_data;
  endtask
endmodule

`default_nettype wire

// ### testbench/test_wavetable_channel_program_port.sv
// Self-checking bench for the wavetable channel programming port
`include "wt_prog_consts.svh"
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

module test_wavetable_channel_program_port;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [3:0] ch; logic [5:0] atten; logic [1:0] osel; logic [7:0] t1; logic [7:0] t2;
    logic [2:0] len; logic [2:0] meth; logic [3:0] k; logic imm; logic oct; logic [7:0] freq;
  } row_t;

  logic i_clk, i_rst_b, i_wr, i_rd;
  logic [15:0] i_table_end, i_sample_tick, i_path_req, o_grant;
  logic [7:0] i_sample1, i_sample2, i_addr, o_mix_data;
  logic [31:0] i_wdata, o_rdata, rdat;
  logic [1:0] o_mix_sel;
  logic o_mix_valid, o_global_sync;
  wire strobe_pin;
  wire [5:0] data_pin;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  logic [15:0] g;
  row_t r;
  row_t rows [4] = '{
    '{4'h0, 6'h2A, 2'h1, 8'hC3, 8'h5A, 3'h5, 3'h2, 4'h9, 1'h0, 1'h1, 8'h37},
    '{4'h1, 6'h15, 2'h2, 8'h3C, 8'hA5, 3'h2, 3'h5, 4'h6, 1'h0, 1'h0, 8'hE4},
    '{4'h2, 6'h3F, 2'h3, 8'hFF, 8'h01, 3'h7, 3'h7, 4'hF, 1'h1, 1'h1, 8'h00},
    '{4'hF, 6'h00, 2'h0, 8'h80, 8'h7E, 3'h0, 3'h1, 4'h0, 1'h0, 1'h0, 8'hEF}};

  host_bus_model host (.o_strobe(strobe_pin), .o_data(data_pin));

  wavetable_channel_program_port dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_strobe(strobe_pin), .i_data(data_pin),
    .i_table_end(i_table_end), .i_sample_tick(i_sample_tick), .i_path_req(i_path_req),
    .i_sample1(i_sample1), .i_sample2(i_sample2), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_grant(o_grant),
    .o_mix_data(o_mix_data), .o_mix_sel(o_mix_sel), .o_mix_valid(o_mix_valid),
    .o_global_sync(o_global_sync));

  // ==========================================================
  // Expected words and bus tasks
  function automatic logic [47:0] pack(row_t x);
    return {x.atten, x.osel, x.t1[7:6], x.t2[7:6], x.t2[5:0], x.t1[5:0], x.len, x.meth,
            x.k, x.imm, x.oct, x.ch, x.freq[1:0], x.freq[7:2]};
  endfunction
  function automatic logic [31:0] lo_word(row_t x);
    return {8'h00, x.atten, x.osel, x.t1, x.t2};
  endfunction
  function automatic logic [31:0] hi_word(row_t x, logic pend);
    return {11'h000, pend, x.len, x.meth, x.k, x.imm, x.oct, x.freq};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rdat = o_rdata;
    `CHK(nm, ex, rdat)
  endtask
  task automatic end_table(input logic [3:0] ch);
    @(posedge i_clk);
    i_table_end <= 16'h0001 << ch;
    @(posedge i_clk);
    i_table_end <= 16'h0000;
  endtask
  task automatic slot(output logic [15:0] gr, output int len);
    len = 0;
    #1;
    while (o_grant === 16'h0000 && len < 50) begin @(posedge i_clk); #1; len++; end
    gr = o_grant;
    len = 0;
    while (o_grant === gr && len < 50) begin @(posedge i_clk); #1; len++; end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #2000000;
    error_cnt++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    i_rst_b = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h00; i_wdata = 32'h0;
    i_table_end = 16'h0; i_sample_tick = 16'h0; i_path_req = 16'h0;
    i_sample1 = 8'h40; i_sample2 = 8'hC0;
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (5) @(posedge i_clk);
    // Reset state and register port edges
    `CHK("sync", 1'b0, o_global_sync)
    chk_rd("status", `WT_ADDR_STATUS, 32'h0000_0000);
    wr(8'h05, 32'h0000_0000);
    chk_rd("ctrl", `WT_ADDR_CTRL, {30'h0, `WT_CTRL_RESET});
    chk_rd("unmapped", 8'h7F, 32'h0000_0000);
    // Ordinary rows: frequency at once, the rest at the table end
    foreach (rows[i]) begin
      r = rows[i];
      host.send(pack(r), 8);
      chk_rd("grp", `WT_ADDR_STATUS, 32'h0000_0000);
      chk_rd("pre_hi", {`WT_PAGE_ACT_HI, r.ch}, {12'h001, 11'h000, r.oct, r.freq});
      chk_rd("pre_lo", {`WT_PAGE_ACT_LO, r.ch}, 32'h0000_0000);
      end_table(r.ch);
      chk_rd("lo", {`WT_PAGE_ACT_LO, r.ch}, lo_word(r));
      chk_rd("hi", {`WT_PAGE_ACT_HI, r.ch}, hi_word(r, 1'b0));
    end
    // Global sync on, then a frequency held to the table end
    r = rows[3]; r.ch = 4'h5; r.freq = `WT_FREQ_SET_SYNC;
    host.send(pack(r), 8);
    `CHK("sync_on", 1'b1, o_global_sync)
    chk_rd("sync_st", `WT_ADDR_STATUS, 32'h0000_0008);
    chk_rd("sync_ch", {`WT_PAGE_ACT_HI, 4'h5}, 32'h0000_0000);
    r = rows[1]; r.ch = 4'h3; r.freq = 8'h21;
    host.send(pack(r), 8);
    chk_rd("sync_pre", {`WT_PAGE_ACT_HI, 4'h3}, 32'h0010_0000);
    end_table(4'h3);
    chk_rd("sync_post", {`WT_PAGE_ACT_HI, 4'h3}, hi_word(r, 1'b0));
    r.freq = `WT_FREQ_CLR_SYNC;
    host.send(pack(r), 8);
    `CHK("sync_off", 1'b0, o_global_sync)
    // One-shot inversion from eight groups of 111110
    host.send({8{6'h3E}}, 8);
    chk_rd("inv_st", `WT_ADDR_STATUS, 32'h0000_0010);
    chk_rd("inv_chf", {`WT_PAGE_ACT_HI, 4'hF}, hi_word(rows[3], 1'b0));
    r = rows[0]; r.ch = 4'h4; r.freq = 8'h40;
    host.send(pack(r), 8);
    chk_rd("inv_once", {`WT_PAGE_ACT_HI, 4'h4}, 32'h0010_0000);
    r.ch = 4'h6; r.freq = 8'h50;
    host.send(pack(r), 8);
    chk_rd("inv_back", {`WT_PAGE_ACT_HI, 4'h6}, {12'h001, 11'h000, r.oct, r.freq});
    // Keep-frequency code
    r = rows[1]; r.atten = 6'h01; r.freq = `WT_FREQ_KEEP;
    host.send(pack(r), 8);
    end_table(4'h1);
    r.freq = rows[1].freq;
    chk_rd("keep", {`WT_PAGE_ACT_HI, 4'h1}, hi_word(r, 1'b0));
    // Forced table end makes all staged values live without a table end
    r = rows[0]; r.ch = 4'h7; r.freq = `WT_FREQ_FORCE_END;
    host.send(pack(r), 8);
    chk_rd("ff_lo", {`WT_PAGE_ACT_LO, 4'h7}, lo_word(r));
    r.freq = 8'h00; r.oct = 1'b0;
    chk_rd("ff_hi", {`WT_PAGE_ACT_HI, 4'h7}, hi_word(r, 1'b0));
    #9000;
    // Partial sequence dropped after the idle timeout
    host.send(pack(rows[0]), 3);
    chk_rd("part", `WT_ADDR_STATUS, 32'h0000_0003);
    repeat (1300) @(posedge i_clk);
    chk_rd("tmo", `WT_ADDR_STATUS, 32'h0000_0000);
    // Programming disabled: strobes ignored
    wr(`WT_ADDR_CTRL, 32'h0000_0001);
    r = rows[2]; r.ch = 4'hA; r.freq = `WT_FREQ_FORCE_END;
    host.send(pack(r), 8);
    chk_rd("prog_off", {`WT_PAGE_ACT_LO, 4'hA}, 32'h0000_0000);
    wr(`WT_ADDR_CTRL, 32'h0000_0003);
    // Full-scale channel made live at once, immediate envelope
    r = rows[2]; r.ch = 4'h8; r.atten = 6'h00; r.freq = `WT_FREQ_FORCE_END;
    host.send(pack(r), 8);
    chk_rd("env_imm", {`WT_PAGE_ENV, 4'h8}, 32'h0000_00FF);
    #9000;
    // Gradual envelope: full-scale target, three full-rate steps
    @(posedge i_clk) i_sample_tick <= 16'h8000;
    repeat (3) @(posedge i_clk);
    i_sample_tick <= 16'h0000;
    chk_rd("env_step", {`WT_PAGE_ENV, 4'hF}, 32'h0000_0003);
    // Shared path: channels 0, 2 and 8 in priority order, 20 cycles each
    @(posedge i_clk) i_path_req <= 16'h0105;
    @(posedge i_clk) i_path_req <= 16'h0104;
    slot(g, n);
    `CHK("grant_0", 16'h0001, g)
    `CHK("slot_0", 32'd20, 32'(n))
    `CHK("valid_0", 1'b1, o_mix_valid)
    `CHK("sel_0", rows[0].osel, o_mix_sel)
    @(posedge i_clk) i_path_req <= 16'h0100;
    slot(g, n);
    `CHK("grant_a", 16'h0004, g)
    `CHK("slot_a", 32'd20, 32'(n))
    `CHK("valid_a", 1'b1, o_mix_valid)
    `CHK("sel_a", rows[2].osel, o_mix_sel)
    slot(g, n);
    `CHK("grant_b", 16'h0100, g)
    `CHK("slot_b", 32'd20, 32'(n))
    `CHK("mix_b", 8'h3F, o_mix_data)
    `CHK("sel_b", 2'h3, o_mix_sel)
    @(posedge i_clk) i_path_req <= 16'h0000;
    // Mid-run reset brings back asynchronous mode and the reset control value
    r = rows[3]; r.freq = `WT_FREQ_SET_SYNC;
    host.send(pack(r), 8);
    `CHK("sync_on2", 1'b1, o_global_sync)
    wr(`WT_ADDR_CTRL, 32'h0000_0001);
    @(posedge i_clk) i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (5) @(posedge i_clk);
    #1;
    `CHK("sync_rst", 1'b0, o_global_sync)
    chk_rd("ctrl_rst", `WT_ADDR_CTRL, {30'h0, `WT_CTRL_RESET});
    close_out();
  end
endmodule

`default_nettype wire

// ### verilog/wavetable_channel_program_port.sv
// Wavetable channel programming port, update control, output path arbiter and envelope
`include "wt_prog_consts.svh"
`default_nettype none

module wavetable_channel_program_port (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Host programming pins
  input wire logic i_strobe,
  input wire logic [5:0] i_data,
  // Table scan side
  input wire logic [15:0] i_table_end,
  input wire logic [15:0] i_sample_tick,
  input wire logic [15:0] i_path_req,
  input wire logic [7:0] i_sample1,
  input wire logic [7:0] i_sample2,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Shared output path
  output logic [15:0] o_grant,
  output logic [7:0] o_mix_data,
  output logic [1:0] o_mix_sel,
  output logic o_mix_valid,
  output logic o_global_sync
);

  wt_prog_pkg::state_t s;
  wt_prog_pkg::state_t next_s;
  logic edge_det;
  logic cap_now;
  logic seq_done;
  logic [7:0] seq_freq;
  logic [3:0] seq_ch;
  wt_prog_pkg::param_t seq_p;

  // ==========================================================
  // Decoding helpers
  function automatic wt_prog_pkg::param_t decode_seq(input logic [6:0][5:0] g,
                                                     input logic [5:0] last);
    wt_prog_pkg::param_t p;
    p.atten = g[0];
    p.out_sel = g[1][5:4];
    p.tab1 = {g[1][3:2], g[3]};
    p.tab2 = {g[1][1:0], g[2]};
    p.table_len = g[4][5:3];
    p.read_method = g[4][2:0];
    p.interp = g[5][5:2];
    p.imm_env = g[5][1];
    p.oct_div = g[5][0];
    p.freq = {last, g[6][1:0]};
    return p;
  endfunction

  // Eight steps of 0.75 dB halve the level, so a mantissa and a shift cover all 64
  function automatic logic [7:0] amp_of(input logic [5:0] atten);
    logic [7:0] m;
    case (atten[2:0])
      3'h0: m = 8'hFF;
      3'h1: m = 8'hEA;
      3'h2: m = 8'hD7;
      3'h3: m = 8'hC5;
      3'h4: m = 8'hB5;
      3'h5: m = 8'hA6;
      3'h6: m = 8'h98;
      default: m = 8'h8C;
    endcase
    return m >> atten[5:3];
  endfunction

  function automatic logic step_ok(input logic [7:0] diff, input logic [2:0] div);
    logic ok;
    if (diff > 8'h80) begin
      ok = 1'b1;
    end else if (diff > 8'h40) begin
      ok = (div[0] == 1'b0);
    end else if (diff > 8'h20) begin
      ok = (div[1:0] == 2'h0);
    end else begin
      ok = (div == 3'h0);
    end
    return ok;
  endfunction

  function automatic logic [3:0] prio(input logic [15:0] req);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (req[i]) begin
        c = 4'(i);
      end
    end
    return c;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] tgt;
    logic [7:0] diff;
    logic signed [13:0] mix_w;
    logic signed [16:0] att_w;
    logic [3:0] k;
    tgt = 8'h00;
    diff = 8'h00;
    mix_w = 14'sh0000;
    att_w = 17'sh00000;
    k = 4'h0;
    next_s = s;
    next_s.mix_valid = 1'b0;
    next_s.rdata = 32'h0000_0000;

    // Pin synchronisers; the first stage feeds only the second
    next_s.strobe_s1 = i_strobe;
    next_s.strobe_s2 = s.strobe_s1;
    next_s.strobe_d = s.strobe_s2;
    next_s.data_s1 = i_data;
    next_s.data_s2 = s.data_s1;
    if (s.sync_age != 2'h3) begin
      next_s.sync_age = s.sync_age + 2'h1;
    end
    // Edges are ignored until the synchroniser holds real pin values
    edge_det = (s.sync_age == 2'h3) && (s.strobe_s2 != s.strobe_d) &&
               s.ctrl[`WT_CTRL_PROG_EN];

    // Capture delay after each edge
    cap_now = s.cap_pend && (s.cap_cnt == 2'h0);
    if (edge_det) begin
      next_s.cap_pend = 1'b1;
      next_s.cap_cnt = 2'(`WT_SAMPLE_CYC - 1);
    end else if (cap_now) begin
      next_s.cap_pend = 1'b0;
    end else if (s.cap_pend) begin
      next_s.cap_cnt = s.cap_cnt - 2'h1;
    end

    // Group counter and inactivity timeout
    seq_done = cap_now && (s.grp == `WT_LAST_GROUP);
    seq_p = decode_seq(s.grp_buf, s.data_s2);
    seq_freq = seq_p.freq;
    seq_ch = s.grp_buf[6][5:2];
    if (edge_det) begin
      next_s.idle_cnt = 11'h000;
    end else if (s.idle_cnt != 11'(`WT_TIMEOUT_CYC)) begin
      next_s.idle_cnt = s.idle_cnt + 11'h001;
    end
    if (cap_now) begin
      if (s.grp != `WT_LAST_GROUP) begin
        next_s.grp_buf[s.grp] = s.data_s2;
      end
      next_s.grp = s.grp + 3'h1;
    end else if (s.idle_cnt == 11'(`WT_TIMEOUT_CYC - 1) && !s.cap_pend) begin
      next_s.grp = 3'h0;
    end

    // Table end promotes staged parameters; otherwise active holds
    for (int c = 0; c < 16; c++) begin
      if (i_table_end[c] && s.pend[c]) begin
        next_s.active[c] = s.stage[c];
        next_s.pend[c] = 1'b0;
      end
    end

    // Completed sequence
    if (seq_done) begin
      if (seq_freq == `WT_FREQ_SET_SYNC) begin
        next_s.global_sync = 1'b1;
      end else if (seq_freq == `WT_FREQ_CLR_SYNC) begin
        next_s.global_sync = 1'b0;
      end else if (seq_freq == `WT_FREQ_INV_SYNC) begin
        next_s.invert_once = 1'b1;
      end else begin
        next_s.invert_once = 1'b0;
        next_s.stage[seq_ch] = seq_p;
        next_s.pend[seq_ch] = 1'b1;
        if (seq_freq == `WT_FREQ_KEEP || seq_freq == `WT_FREQ_FORCE_END) begin
          next_s.stage[seq_ch].freq = s.stage[seq_ch].freq;
          next_s.stage[seq_ch].oct_div = s.stage[seq_ch].oct_div;
        end else if (!(s.global_sync ^ s.invert_once)) begin
          next_s.active[seq_ch].freq = seq_freq;
          next_s.active[seq_ch].oct_div = seq_p.oct_div;
        end
        if (seq_freq == `WT_FREQ_FORCE_END) begin
          next_s.active[seq_ch] = next_s.stage[seq_ch];
          next_s.pend[seq_ch] = 1'b0;
        end
      end
    end

    // Envelope follows the active attenuation
    for (int c = 0; c < 16; c++) begin
      tgt = amp_of(s.active[c].atten);
      diff = (tgt > s.env[c]) ? (tgt - s.env[c]) : (s.env[c] - tgt);
      if (s.active[c].imm_env) begin
        next_s.env[c] = tgt;
      end else if (i_sample_tick[c]) begin
        next_s.env_div[c] = s.env_div[c] + 3'h1;
        if (diff != 8'h00 && step_ok(diff, s.env_div[c])) begin
          next_s.env[c] = (tgt > s.env[c]) ? s.env[c] + 8'h01 : s.env[c] - 8'h01;
        end
      end
    end

    // Shared output path
    case (s.arb)
      wt_prog_pkg::ARB_IDLE: begin
        if (s.ctrl[`WT_CTRL_PATH_EN] && (|i_path_req)) begin
          next_s.grant_ch = prio(i_path_req);
          next_s.grant = 16'h0001 << prio(i_path_req);
          next_s.slot_cnt = 5'(`WT_SLOT_CYC - 1);
          next_s.arb = wt_prog_pkg::ARB_BUSY;
        end
      end
      wt_prog_pkg::ARB_BUSY: begin
        if (s.slot_cnt == 5'h00) begin
          k = s.active[s.grant_ch].interp;
          // Widen the weight before adding one, else K of 15 wraps to a zero weight
          mix_w = $signed(i_sample1) * $signed({2'b00, k} + 6'h01) +
                  $signed(i_sample2) * $signed({1'b0, 4'hF - k});
          att_w = $signed(mix_w[11:4]) * $signed({1'b0, s.env[s.grant_ch]});
          next_s.mix_data = att_w[15:8];
          next_s.mix_sel = s.active[s.grant_ch].out_sel;
          next_s.mix_valid = 1'b1;
          next_s.grant = 16'h0000;
          next_s.arb = wt_prog_pkg::ARB_IDLE;
        end else begin
          next_s.slot_cnt = s.slot_cnt - 5'h01;
        end
      end
      default: begin
        next_s.arb = wt_prog_pkg::ARB_IDLE;
      end
    endcase

    // Register port
    if (i_wr && i_addr == `WT_ADDR_CTRL) begin
      next_s.ctrl = i_wdata[1:0];
    end
    if (i_rd) begin
      case (i_addr[7:4])
        4'h0: begin
          if (i_addr == `WT_ADDR_STATUS) begin
            next_s.rdata = {27'h0, s.invert_once, s.global_sync, s.grp};
          end else if (i_addr == `WT_ADDR_CTRL) begin
            next_s.rdata = {30'h0, s.ctrl};
          end
        end
        `WT_PAGE_ACT_LO: begin
          next_s.rdata = {8'h00, s.active[i_addr[3:0]].atten, s.active[i_addr[3:0]].out_sel,
                          s.active[i_addr[3:0]].tab1, s.active[i_addr[3:0]].tab2};
        end
        `WT_PAGE_ACT_HI: begin
          next_s.rdata = {11'h000, s.pend[i_addr[3:0]], s.active[i_addr[3:0]].table_len,
                          s.active[i_addr[3:0]].read_method, s.active[i_addr[3:0]].interp,
                          s.active[i_addr[3:0]].imm_env, s.active[i_addr[3:0]].oct_div,
                          s.active[i_addr[3:0]].freq};
        end
        `WT_PAGE_ENV: begin
          next_s.rdata = {24'h000000, s.env[i_addr[3:0]]};
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
      s.ctrl <= `WT_CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign o_rdata = s.rdata;
  assign o_grant = s.grant;
  assign o_mix_data = s.mix_data;
  assign o_mix_sel = s.mix_sel;
  assign o_mix_valid = s.mix_valid;
  assign o_global_sync = s.global_sync;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_sync_set_cmd: assert property (seq_done && seq_freq == 8'hF9 |=> s.global_sync)
    else $error("Set sync command did not enable global sync");
  a_sync_clear_cmd: assert property (seq_done && seq_freq == 8'hFB |=> !s.global_sync)
    else $error("Clear sync command did not disable global sync");
  a_sync_invert_once: assert property (seq_done && s.invert_once && seq_freq < 8'hF9
    |=> !s.invert_once && s.global_sync == $past(s.global_sync))
    else $error("Sync inversion not consumed by next sequence");
  a_capture_delay: assert property (edge_det |=> s.cap_pend [*3] ##1 !s.cap_pend)
    else $error("Data bus not sampled three cycles after strobe edge");
  a_timeout_reset: assert property (s.idle_cnt == 11'd1279 && !s.cap_pend && s.grp != 3'h0
    |=> s.grp == 3'h0)
    else $error("Group counter not reset after inactivity");
  a_path_slot: assert property ($rose(s.arb == wt_prog_pkg::ARB_BUSY)
    |-> ##19 s.arb == wt_prog_pkg::ARB_BUSY ##1 s.arb == wt_prog_pkg::ARB_IDLE)
    else $error("Output path slot is not twenty cycles");
  a_path_priority: assert property (s.arb == wt_prog_pkg::ARB_IDLE && s.ctrl[0] && i_path_req[0]
    |=> s.grant == 16'h0001)
    else $error("Channel zero not granted first");
  a_force_end_apply: assert property (seq_done && seq_freq == 8'hFF
    |=> s.active[$past(seq_ch)] == s.stage[$past(seq_ch)])
    else $error("Forced table end did not activate staged parameters");
  a_async_freq: assert property (seq_done && seq_freq < 8'hF9 && !(s.global_sync ^ s.invert_once)
    |=> s.active[$past(seq_ch)].freq == $past(seq_freq))
    else $error("Asynchronous frequency not applied at once");
  a_sync_freq_held: assert property (seq_done && seq_freq < 8'hF9 && (s.global_sync ^ s.invert_once)
    && !i_table_end[seq_ch] |=> s.active[$past(seq_ch)].freq == $past(s.active[seq_ch].freq))
    else $error("Synchronous frequency applied before table end");
  a_envelope_step: assert property (!s.active[15].imm_env
    |=> (s.env[15] - $past(s.env[15]) == 8'h00) || (s.env[15] - $past(s.env[15]) == 8'h01)
    || ($past(s.env[15]) - s.env[15] == 8'h01))
    else $error("Gradual envelope moved by more than one step");
  a_stage_promote: assert property (i_table_end[0] && s.pend[0] && !seq_done
    |=> s.active[0] == $past(s.stage[0]) && !s.pend[0])
    else $error("Staged parameters not made active at the table end");
  a_keep_freq: assert property (seq_done && seq_freq == 8'hFC
    |=> s.stage[$past(seq_ch)].freq == $past(s.stage[seq_ch].freq))
    else $error("Keep frequency code changed the staged frequency");
  a_grant_onehot: assert property ($onehot0(s.grant))
    else $error("More than one channel holds the output path");
  a_mix_after_slot: assert property (s.mix_valid
    |-> s.grant == 16'h0000 && s.arb == wt_prog_pkg::ARB_IDLE)
    else $error("Mix result issued while the path is still held");

  c_sequence_done: cover property (seq_done && seq_freq < 8'hF9);
  c_force_end: cover property (seq_done && seq_freq == 8'hFF);
  c_path_mix: cover property (s.mix_valid);
  c_sync_mode: cover property (s.global_sync && seq_done);
  c_env_step: cover property (s.env[15] != 8'h00);

endmodule

`default_nettype wire

// ### verilog/wt_prog_consts.svh
// Constants for the wavetable channel programming port
`ifndef WT_PROG_CONSTS_SVH
`define WT_PROG_CONSTS_SVH

// ==========================================================
// Timing
`define WT_CLK_PERIOD_NS 100
`define WT_SAMPLE_DELAY_NS 250
`define WT_TIMEOUT_NS 128000
`define WT_SLOT_NS 2000
`define WT_SAMPLE_CYC ((`WT_SAMPLE_DELAY_NS + `WT_CLK_PERIOD_NS - 1) / `WT_CLK_PERIOD_NS)
`define WT_TIMEOUT_CYC (`WT_TIMEOUT_NS / `WT_CLK_PERIOD_NS)
`define WT_SLOT_CYC (`WT_SLOT_NS / `WT_CLK_PERIOD_NS)

// ==========================================================
// Sequence layout and special frequency codes
`define WT_LAST_GROUP 3'h7
`define WT_FREQ_SET_SYNC 8'hF9
`define WT_FREQ_INV_SYNC 8'hFA
`define WT_FREQ_CLR_SYNC 8'hFB
`define WT_FREQ_KEEP 8'hFC
`define WT_FREQ_FORCE_END 8'hFF

// ==========================================================
// Register port map
`define WT_ADDR_STATUS 8'h00
`define WT_ADDR_CTRL 8'h01
`define WT_PAGE_ACT_LO 4'h1
`define WT_PAGE_ACT_HI 4'h2
`define WT_PAGE_ENV 4'h3
`define WT_CTRL_RESET 2'h3
`define WT_CTRL_PATH_EN 0
`define WT_CTRL_PROG_EN 1

`endif

// ### verilog/wt_prog_pkg.sv
// Types for the wavetable channel programming port
`default_nettype none

package wt_prog_pkg;

  typedef struct packed {
    logic [5:0] atten;
    logic [1:0] out_sel;
    logic [7:0] tab1;
    logic [7:0] tab2;
    logic [2:0] table_len;
    logic [2:0] read_method;
    logic [3:0] interp;
    logic imm_env;
    logic oct_div;
    logic [7:0] freq;
  } param_t;

  typedef enum logic {ARB_IDLE, ARB_BUSY} arb_t;

  typedef struct packed {
    logic strobe_s1;
    logic strobe_s2;
    logic strobe_d;
    logic [1:0] sync_age;
    logic [5:0] data_s1;
    logic [5:0] data_s2;
    logic cap_pend;
    logic [1:0] cap_cnt;
    logic [2:0] grp;
    logic [6:0][5:0] grp_buf;
    logic [10:0] idle_cnt;
    logic global_sync;
    logic invert_once;
    logic [1:0] ctrl;
    logic [31:0] rdata;
    param_t [15:0] stage;
    param_t [15:0] active;
    logic [15:0] pend;
    logic [15:0][7:0] env;
    logic [15:0][2:0] env_div;
    arb_t arb;
    logic [4:0] slot_cnt;
    logic [3:0] grant_ch;
    logic [15:0] grant;
    logic [7:0] mix_data;
    logic [1:0] mix_sel;
    logic mix_valid;
  } state_t;

endpackage

`default_nettype wire
